/* common/rtc_host_regs.vh */
`ifndef RTC_HOST_REGS_VH
`define RTC_HOST_REGS_VH

// ==========================================================
// Timing
`define CLK_PERIOD_NS  100
`define SCL_PERIOD_NS  10000
`define QTR_CYC        (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define TBUF_NS        4700
`define TBUF_CYC       ((`TBUF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W        8

// ==========================================================
// Bus addressing
`define RTC_SLAVE_ADDR 7'h68
`define DIR_WRITE      1'b0
`define DIR_READ       1'b1

// ==========================================================
// Byte framing
`define BYTE_W         8
`define BIT_W          4
`define BIT_ACK        4'h8
`define BIT_ZERO       4'h0
`define CNT_ZERO       8'h00
`define CNT_ONE        8'h01

// ==========================================================
// Quarter phases of one bus clock period
`define Q0             2'h0
`define Q1             2'h1
`define Q2             2'h2
`define Q3             2'h3

// ==========================================================
// Write data buffer
`define FIFO_DEPTH     32
`define FIFO_AW        5

`endif

/* hdl/byte_fifo.v */
`timescale 1ns/1ps
`include "rtc_host_regs.vh"

module byte_fifo #(
   parameter W     = `BYTE_W,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW    = `FIFO_AW
) (
   input  wire          i_mclk,       // System clock
   input  wire          i_rst,        // Synchronous reset, active high
   input  wire [W-1:0]  i_in_data,    // Fill side data
   input  wire          i_in_valid,   // Fill side valid
   output wire          o_in_ready,   // Fill side ready (not full)
   output wire [W-1:0]  o_out_data,   // Drain side data
   output wire          o_out_valid,  // Drain side valid (not empty)
   input  wire          i_out_ready   // Drain side ready
);

   // ==========================================================
   // Storage and pointers
   reg  [W-1:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wr_ptr_r;
   reg  [AW-1:0] rd_ptr_r;
   reg  [AW:0]   count_r;
   wire          push;
   wire          pop;

   assign o_in_ready  = (count_r != DEPTH[AW:0]);
   assign o_out_valid = (count_r != {(AW+1){1'b0}});
   assign push        = i_in_valid && o_in_ready;
   assign pop         = i_out_ready && o_out_valid;
   assign o_out_data  = mem[rd_ptr_r];

   always @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   always @(posedge i_mclk) begin
      if (i_rst) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule

/* hdl/rtc_i2c_master.v */
// What this block does
// - Idle means both lines high
// - SDA falling with SCL high is START
// - SDA rising with SCL high is STOP
// - SDA changes only while SCL low
// - Master starts only on idle bus
// - Eight-bit bytes plus ninth acknowledge slot
// - Standard mode rate only
// - Acknowledger holds SDA low through pulse
// - Bytes shifted most significant bit first
// - Repeated START opens next transfer
// - First byte: address then direction bit
// - Direction one selects device transmit
// - First write byte loads register pointer
// - Read continues until master not-acknowledge
// - Master acknowledges all but last byte
// - Master makes all clocks, START, STOP
`timescale 1ns/1ps
`include "rtc_host_regs.vh"

module rtc_i2c_master (
   input  wire        i_mclk,      // System clock, 10 MHz
   input  wire        i_rst,       // Synchronous reset, active high
   input  wire        i_go,        // Request strobe, taken when not busy
   input  wire        i_rd,        // 1 = read request, 0 = write request
   input  wire        i_set_ptr,   // Read: write pointer first
   input  wire [7:0]  i_ptr,       // Register pointer to load
   input  wire [7:0]  i_len,       // Data byte count
   output wire        o_busy,      // Request in progress
   output reg         o_done,      // One-cycle pulse at end of request
   output reg         o_nack,      // Last request saw a missing acknowledge
   input  wire [7:0]  i_wr_data,   // Write data into buffer
   input  wire        i_wr_valid,  // Write data valid
   output wire        o_wr_ready,  // Buffer can take write data
   output reg  [7:0]  o_rd_data,   // Read data byte
   output reg         o_rd_valid,  // One-cycle pulse with read data
   input  wire        i_scl_in,    // Clock line level
   output wire        o_scl_out,   // Clock line drive value
   output reg         o_scl_oe,    // Clock line pulled low while high
   input  wire        i_sda_in,    // Data line level
   output wire        o_sda_out,   // Data line drive value
   output reg         o_sda_oe     // Data line pulled low while high
);

   // ==========================================================
   // Constants and states
   localparam integer        QTR_LAST_I = `QTR_CYC - 1;
   localparam integer        BUF_LAST_I = `TBUF_CYC - 1;
   localparam [`TIMER_W-1:0] QTR_LAST   = QTR_LAST_I[`TIMER_W-1:0];
   localparam [`TIMER_W-1:0] BUF_LAST   = BUF_LAST_I[`TIMER_W-1:0];

   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_BUF    = 3'h1;
   localparam [2:0] S_START  = 3'h2;
   localparam [2:0] S_BYTE   = 3'h3;
   localparam [2:0] S_RSTART = 3'h4;
   localparam [2:0] S_STOP   = 3'h5;
   localparam [2:0] S_FETCH  = 3'h6;

   localparam [1:0] K_ADDR  = 2'h0;
   localparam [1:0] K_PTR   = 2'h1;
   localparam [1:0] K_WDATA = 2'h2;
   localparam [1:0] K_RDATA = 2'h3;

   // ==========================================================
   // Declarations
   reg  [2:0]          state_r;
   reg  [1:0]          kind_r;
   reg  [1:0]          qi_r;
   reg  [`TIMER_W-1:0] q_cnt_r;
   reg  [`TIMER_W-1:0] buf_cnt_r;
   reg  [`BIT_W-1:0]   bit_r;
   reg  [7:0]          sh_r;
   reg  [7:0]          cnt_r;
   reg  [7:0]          last_r;
   reg  [7:0]          ptr_r;
   reg                 rd_r;
   reg                 rphase_r;
   reg                 ack_r;
   reg                 len_zero_r;
   reg                 scl_m_r;
   reg                 scl_s_r;
   reg                 sda_m_r;
   reg                 sda_s_r;
   wire                timed;
   wire                stretch;
   wire                tick;
   wire                last_byte;
   wire [7:0]          fifo_data;
   wire                fifo_valid;
   wire                fifo_pop;

   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;
   assign o_busy    = (state_r != S_IDLE);
   assign last_byte = (cnt_r == last_r);

   // ==========================================================
   // Pin synchronisers
   always @(posedge i_mclk) begin
      if (i_rst) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
      end else begin
         scl_m_r <= i_scl_in;
         scl_s_r <= scl_m_r;
         sda_m_r <= i_sda_in;
         sda_s_r <= sda_m_r;
      end
   end

   // ==========================================================
   // Write data buffer
   assign fifo_pop = (state_r == S_FETCH);

   byte_fifo #(
      .W     (`BYTE_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_wr_fifo (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_in_data   (i_wr_data),
      .i_in_valid  (i_wr_valid),
      .o_in_ready  (o_wr_ready),
      .o_out_data  (fifo_data),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_pop)
   );

   // ==========================================================
   // Quarter-period timer
   // Four quarters of 25 cycles give a 100 kHz bus clock.
   // A released clock still held low by the far end stalls the timer.
   assign timed   = (state_r == S_START) || (state_r == S_BYTE) ||
                    (state_r == S_RSTART) || (state_r == S_STOP);
   assign stretch = !o_scl_oe && !scl_s_r;
   assign tick    = timed && !stretch && (q_cnt_r == QTR_LAST);

   always @(posedge i_mclk) begin
      if (i_rst || !timed) begin
         q_cnt_r <= {`TIMER_W{1'b0}};
         qi_r    <= `Q0;
      end else if (!stretch) begin
         if (tick) begin
            q_cnt_r <= {`TIMER_W{1'b0}};
            qi_r    <= qi_r + 2'h1;
         end else begin
            q_cnt_r <= q_cnt_r + {{(`TIMER_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================
   // Transfer sequencer
   always @(posedge i_mclk) begin
      if (i_rst) begin
         state_r    <= S_IDLE;
         kind_r     <= K_ADDR;
         buf_cnt_r  <= {`TIMER_W{1'b0}};
         bit_r      <= `BIT_ZERO;
         sh_r       <= 8'h00;
         cnt_r      <= `CNT_ZERO;
         last_r     <= `CNT_ZERO;
         ptr_r      <= 8'h00;
         rd_r       <= 1'b0;
         rphase_r   <= 1'b0;
         ack_r      <= 1'b1;
         len_zero_r <= 1'b1;
         o_scl_oe   <= 1'b0;
         o_sda_oe   <= 1'b0;
         o_done     <= 1'b0;
         o_nack     <= 1'b0;
         o_rd_data  <= 8'h00;
         o_rd_valid <= 1'b0;
      end else begin
         o_done     <= 1'b0;
         o_rd_valid <= 1'b0;
         case (state_r)
            S_IDLE: begin
               o_scl_oe  <= 1'b0;
               o_sda_oe  <= 1'b0;
               buf_cnt_r <= {`TIMER_W{1'b0}};
               if (i_go) begin
                  rd_r       <= i_rd;
                  ptr_r      <= i_ptr;
                  rphase_r   <= i_rd && !i_set_ptr;
                  len_zero_r <= (i_len == `CNT_ZERO);
                  last_r     <= (i_len == `CNT_ZERO) ? `CNT_ZERO : (i_len - `CNT_ONE);
                  o_nack     <= 1'b0;
                  state_r    <= S_BUF;
               end
            end
            S_BUF: begin
               // Both lines must stay high for a full bus free time
               if (scl_s_r && sda_s_r) begin
                  if (buf_cnt_r == BUF_LAST) begin
                     state_r <= S_START;
                  end else begin
                     buf_cnt_r <= buf_cnt_r + {{(`TIMER_W-1){1'b0}}, 1'b1};
                  end
               end else begin
                  buf_cnt_r <= {`TIMER_W{1'b0}};
               end
            end
            S_START: begin
               if (tick && qi_r == `Q1) begin
                  o_sda_oe <= 1'b1;
               end
               if (tick && qi_r == `Q3) begin
                  o_scl_oe <= 1'b1;
                  sh_r     <= {`RTC_SLAVE_ADDR, rphase_r};
                  kind_r   <= K_ADDR;
                  bit_r    <= `BIT_ZERO;
                  cnt_r    <= `CNT_ZERO;
                  state_r  <= S_BYTE;
               end
            end
            S_BYTE: begin
               if (tick) begin
                  case (qi_r)
                     `Q0: begin
                        // Data changes only in the low half of the clock
                        if (bit_r == `BIT_ACK) begin
                           if (kind_r == K_RDATA) begin
                              o_sda_oe <= !last_byte;
                           end else begin
                              o_sda_oe <= 1'b0;
                           end
                        end else if (kind_r == K_RDATA) begin
                           o_sda_oe <= 1'b0;
                        end else begin
                           o_sda_oe <= !sh_r[7];
                        end
                     end
                     `Q1: begin
                        o_scl_oe <= 1'b0;
                     end
                     `Q2: begin
                        if (bit_r == `BIT_ACK) begin
                           ack_r <= sda_s_r;
                        end else begin
                           sh_r <= {sh_r[6:0], sda_s_r};
                        end
                     end
                     `Q3: begin
                        o_scl_oe <= 1'b1;
                        if (bit_r != `BIT_ACK) begin
                           bit_r <= bit_r + 4'h1;
                        end else begin
                           bit_r <= `BIT_ZERO;
                           case (kind_r)
                              K_ADDR: begin
                                 if (ack_r) begin
                                    o_nack  <= 1'b1;
                                    state_r <= S_STOP;
                                 end else if (rphase_r) begin
                                    kind_r <= K_RDATA;
                                 end else begin
                                    kind_r <= K_PTR;
                                    sh_r   <= ptr_r;
                                 end
                              end
                              K_PTR: begin
                                 if (ack_r) begin
                                    o_nack  <= 1'b1;
                                    state_r <= S_STOP;
                                 end else if (rd_r) begin
                                    rphase_r <= 1'b1;
                                    state_r  <= S_RSTART;
                                 end else if (len_zero_r) begin
                                    state_r <= S_STOP;
                                 end else begin
                                    kind_r  <= K_WDATA;
                                    state_r <= S_FETCH;
                                 end
                              end
                              K_WDATA: begin
                                 cnt_r <= cnt_r + `CNT_ONE;
                                 if (ack_r) begin
                                    o_nack  <= 1'b1;
                                    state_r <= S_STOP;
                                 end else if (last_byte) begin
                                    state_r <= S_STOP;
                                 end else begin
                                    state_r <= S_FETCH;
                                 end
                              end
                              default: begin
                                 cnt_r      <= cnt_r + `CNT_ONE;
                                 o_rd_data  <= sh_r;
                                 o_rd_valid <= 1'b1;
                                 o_sda_oe   <= 1'b0;
                                 if (last_byte) begin
                                    state_r <= S_STOP;
                                 end
                              end
                           endcase
                        end
                     end
                     default: begin
                        o_scl_oe <= 1'b1;
                     end
                  endcase
               end
            end
            S_FETCH: begin
               // Clock held low until the buffer offers a byte
               o_sda_oe <= 1'b0;
               if (fifo_valid) begin
                  sh_r    <= fifo_data;
                  state_r <= S_BYTE;
               end
            end
            S_RSTART: begin
               if (tick && qi_r == `Q0) begin
                  o_sda_oe <= 1'b0;
               end
               if (tick && qi_r == `Q1) begin
                  o_scl_oe <= 1'b0;
               end
               if (tick && qi_r == `Q3) begin
                  state_r <= S_START;
               end
            end
            S_STOP: begin
               if (tick && qi_r == `Q0) begin
                  o_sda_oe <= 1'b1;
               end
               if (tick && qi_r == `Q1) begin
                  o_scl_oe <= 1'b0;
               end
               if (tick && qi_r == `Q3) begin
                  o_sda_oe <= 1'b0;
                  o_done   <= 1'b1;
                  state_r  <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule

/* testbench/rtc_i2c_master_assertions.sv */
`timescale 1ns/1ps
module rtc_i2c_master_checker (
   input wire i_mclk,     // System clock
   input wire i_rst,      // Synchronous reset
   input wire i_go,       // Request strobe
   input wire o_busy,     // Request in progress
   input wire o_done,     // End of request
   input wire o_nack,     // Missing acknowledge seen
   input wire o_rd_valid, // Read byte strobe
   input wire i_scl_in,   // Clock line level
   input wire o_scl_oe,   // Clock line pull-down
   input wire o_sda_oe    // Data line pull-down
);
   // ==========
   // Length of the present clock-drive phase, saturating
   reg       scl_q;
   reg [7:0] run_r;
   always @(posedge i_mclk) begin
      if (i_rst) begin
         scl_q <= 1'b0;
         run_r <= 8'h00;
      end else begin
         scl_q <= o_scl_oe;
         run_r <= (o_scl_oe != scl_q) ? 8'h00 : run_r + {7'h00, run_r != 8'hFF};
      end
   end

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   // ==========
   // Protocol checks
   go_sets_busy_a: assert property (i_go && !o_busy |=> o_busy)
      else $error("busy not raised after request");
   idle_released_a: assert property (!o_busy |-> !o_scl_oe && !o_sda_oe)
      else $error("line driven while idle");
   bus_free_a: assert property (i_go && !o_busy |=> (!o_scl_oe && !o_sda_oe)[*8] ##[32:120] $rose(o_sda_oe))
      else $error("start not preceded by free bus");
   start_hold_a: assert property ($rose(o_sda_oe) && i_scl_in |-> ##[40:60] $rose(o_scl_oe))
      else $error("start hold time wrong");
   stop_done_a: assert property ($fell(o_sda_oe) && i_scl_in |-> ##[0:120] o_done)
      else $error("stop not followed by completion");
   scl_high_a: assert property ($rose(o_scl_oe) |-> run_r >= 8'h27)
      else $error("clock high phase too short");
   scl_low_a: assert property ($fell(o_scl_oe) |-> run_r >= 8'h2E)
      else $error("clock low phase too short");
   done_pulse_a: assert property (o_done |=> !o_done)
      else $error("done longer than one cycle");
   rd_pulse_a: assert property (o_rd_valid |=> !o_rd_valid[*8])
      else $error("read strobes too close");
   nack_clear_a: assert property (i_go && !o_busy |=> !o_nack)
      else $error("nack flag not cleared by request");
endmodule

bind rtc_i2c_master rtc_i2c_master_checker chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(i_go),
   .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack), .o_rd_valid(o_rd_valid),
   .i_scl_in(i_scl_in), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));

/* testbench/rtc_dev_model.sv */
`timescale 1ns/1ps
module rtc_dev_model (
   input  wire       i_mclk,   // Sampling clock
   input  wire       i_scl,    // Clock line level
   input  wire       i_sda,    // Data line level
   input  wire [6:0] i_addr,   // Address answered to
   input  wire       i_slow,   // Stretch clock in receive ack slots
   output reg        o_scl_oe, // Pull clock line low
   output reg        o_sda_oe  // Pull data line low
);
   reg [7:0] mem [0:63];
   reg [7:0] ptr_r = 8'h00;
   reg [7:0] sh_r  = 8'h00;
   reg [7:0] tx_r  = 8'h00;
   reg [3:0] bit_r = 4'h0;
   reg [1:0] st_r  = 2'h0;  // 0 ignore, 1 address, 2 receive, 3 transmit
   reg       scl_q = 1'b1, sda_q = 1'b1, ackd = 1'b0, first = 1'b0;
   integer   hold  = 0, i;

   function [7:0] inc(input [7:0] p);
      inc = (p == 8'h3F) ? 8'h00 : p + 8'h01;
   endfunction

   initial begin
      o_scl_oe = 1'b0;
      o_sda_oe = 1'b0;
      for (i = 0; i < 64; i = i + 1) mem[i] = i[7:0];
   end

   always @(posedge i_mclk) begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (hold > 0) begin
         hold <= hold - 1;
         if (hold == 1) o_scl_oe <= 1'b0;
      end
      if (scl_q && i_scl && sda_q && !i_sda) begin
         st_r     <= 2'h1;
         bit_r    <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (scl_q && i_scl && !sda_q && i_sda) begin
         st_r     <= 2'h0;
         o_sda_oe <= 1'b0;
      end else if (st_r != 2'h0 && !scl_q && i_scl) begin
         bit_r <= bit_r + 4'h1;
         if (bit_r < 4'h8) sh_r <= {sh_r[6:0], i_sda};
         else ackd <= !i_sda;
      end else if (st_r != 2'h0 && scl_q && !i_scl) begin
         if (bit_r == 4'h8) begin
            if (st_r == 2'h1) begin
               if (sh_r[7:1] == i_addr) begin
                  o_sda_oe <= 1'b1;
                  st_r     <= sh_r[0] ? 2'h3 : 2'h2;
                  first    <= 1'b1;
               end else st_r <= 2'h0;
            end else if (st_r == 2'h2) begin
               o_sda_oe <= 1'b1;
               first    <= 1'b0;
               if (first) ptr_r <= sh_r;
               else begin
                  mem[ptr_r[5:0]] <= sh_r;
                  ptr_r <= inc(ptr_r);
               end
               if (i_slow) begin
                  o_scl_oe <= 1'b1;
                  hold     <= 80;
               end
            end else o_sda_oe <= 1'b0;
         end else if (bit_r == 4'h9) begin
            bit_r <= 4'h0;
            if (st_r == 2'h3 && ackd) begin
               tx_r     <= mem[ptr_r[5:0]];
               o_sda_oe <= !mem[ptr_r[5:0]][7];
               ptr_r    <= inc(ptr_r);
            end else begin
               o_sda_oe <= 1'b0;
               if (st_r == 2'h3) st_r <= 2'h0;
            end
         end else if (st_r == 2'h3) o_sda_oe <= !tx_r[4'h7 - bit_r];
      end
   end
endmodule

/* testbench/rtc_i2c_master_tb_top.sv */
`timescale 1ns/1ps
module rtc_i2c_master_tb_top;
   reg         i_mclk = 1'b0, i_rst = 1'b1, i_go = 1'b0, i_rd = 1'b0, i_set_ptr = 1'b0;
   reg         i_wr_valid = 1'b0, slow = 1'b0;
   reg  [7:0]  i_ptr = 8'h00, i_len = 8'h00, i_wr_data = 8'h00, pnt = 8'h00;
   reg  [6:0]  dev_addr = 7'h68;
   reg  [31:0] seed = 32'h0001_2A75, r = 32'h0000_0000;
   reg  [7:0]  mem [0:63];
   wire [7:0]  o_rd_data;
   wire        o_busy, o_done, o_nack, o_wr_ready, o_rd_valid;
   wire        o_scl_oe, o_sda_oe, d_scl_oe, d_sda_oe;
   wire        scl = !(o_scl_oe | d_scl_oe);
   wire        sda = !(o_sda_oe | d_sda_oe);
   integer     bad_count = 0, comparisons = 0, rx_n = 0, i;

   always #50 i_mclk = ~i_mclk;

   rtc_i2c_master dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(i_go), .i_rd(i_rd),
      .i_set_ptr(i_set_ptr), .i_ptr(i_ptr), .i_len(i_len), .o_busy(o_busy), .o_done(o_done),
      .o_nack(o_nack), .i_wr_data(i_wr_data), .i_wr_valid(i_wr_valid),
      .o_wr_ready(o_wr_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
      .i_scl_in(scl), .o_scl_out(), .o_scl_oe(o_scl_oe), .i_sda_in(sda), .o_sda_out(),
      .o_sda_oe(o_sda_oe));
   rtc_dev_model dev (.i_mclk(i_mclk), .i_scl(scl), .i_sda(sda), .i_addr(dev_addr),
      .i_slow(slow), .o_scl_oe(d_scl_oe), .o_sda_oe(d_sda_oe));

   // ==========
   // Helpers
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction

   function [7:0] nxt(input [7:0] p);
      nxt = (p == 8'h3F) ? 8'h00 : p + 8'h01;
   endfunction

   task check(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
         end
      end
   endtask

   task end_of_test;
      begin
         $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
         if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   task push(input [7:0] d);
      begin
         @(negedge i_mclk);
         i_wr_data  = d;
         i_wr_valid = 1'b1;
         @(negedge i_mclk);
         i_wr_valid = 1'b0;
      end
   endtask

   task xfer(input rd, input sp, input [7:0] ptr, input [7:0] len);
      integer k;
      begin
         rx_n = 0;
         @(negedge i_mclk);
         {i_rd, i_set_ptr, i_ptr, i_len, i_go} = {rd, sp, ptr, len, 1'b1};
         @(negedge i_mclk);
         i_go = 1'b0;
         check(o_busy, 8'h01);
         for (k = 0; k < 40000 && o_done !== 1'b1; k = k + 1) begin
            @(negedge i_mclk);
            if (o_rd_valid === 1'b1) begin
               check(o_rd_data, mem[pnt[5:0]]);
               pnt  = nxt(pnt);
               rx_n = rx_n + 1;
            end
         end
         if (k == 40000) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: transfer never completed", $time);
            end_of_test;
         end
         if (rd) check(rx_n[7:0], (len == 8'h00) ? 8'h01 : len);
         $display("Test finished: rd=%0d ptr=%h len=%0d", rd, ptr, len);
      end
   endtask

   // Queue write data and mirror it where the device will store it
   task fill(input [7:0] ptr, input integer cnt);
      integer j;
      begin
         pnt = ptr;
         for (j = 0; j < cnt; j = j + 1) begin
            seed = xs(seed);
            push(seed[7:0]);
            mem[pnt[5:0]] = seed[7:0];
            pnt = nxt(pnt);
         end
      end
   endtask

   task wr(input [7:0] ptr, input integer cnt);
      begin
         fill(ptr, cnt);
         xfer(1'b0, 1'b0, ptr, cnt[7:0]);
      end
   endtask

   task rd(input sp, input [7:0] ptr, input [7:0] len);
      begin
         if (sp) pnt = ptr;
         xfer(1'b1, sp, ptr, len);
      end
   endtask

   // ==========
   // Main sequence
   initial begin
      for (i = 0; i < 64; i = i + 1) mem[i] = i[7:0];
      repeat (5) @(negedge i_mclk);
      i_rst = 1'b0;
      check({o_busy, o_done, o_nack, o_rd_valid, o_scl_oe, o_sda_oe, o_wr_ready}, 8'h01);
      slow = 1'b1;
      wr(8'h3E, 3);
      slow = 1'b0;
      rd(1'b1, 8'h3E, 8'h03);
      rd(1'b0, 8'h00, 8'h02);
      wr(8'h10, 0);
      rd(1'b0, 8'h00, 8'h00);
      dev_addr = 7'h55;
      xfer(1'b0, 1'b0, 8'h05, 8'h00);
      check(o_nack, 8'h01);
      dev_addr = 7'h68;
      rd(1'b0, 8'h00, 8'h01);
      check(o_nack, 8'h00);
      slow = 1'b1;
      fill(8'h20, 32);
      check(o_wr_ready, 8'h00);
      push(8'hA5);
      xfer(1'b0, 1'b0, 8'h20, 8'h20);
      check(o_wr_ready, 8'h01);
      slow = 1'b0;
      rd(1'b1, 8'h3D, 8'h04);
      for (i = 0; i < 2; i = i + 1) begin
         seed = xs(seed);
         r    = seed;
         wr({2'h0, r[5:0]}, r[9:8] + 1);
         rd(1'b1, {2'h0, r[5:0]}, {6'h00, r[9:8]} + 8'h01);
      end
      end_of_test;
   end
endmodule
